// File: hw/pbl_axil_slave.sv
// pbl_axil_slave: axi4-lite handshake front end for the loader registers
// assumes: decode and read mux in the parent
`timescale 1ns/10ps
module pbl_axil_slave
   import pbl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [PBL_AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [PBL_AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic regWrEn,
   output logic [PBL_AXI_AW-1:0] regWrAddr,
   output logic [31:0] regWrData,
   output logic [3:0] regWrStrb,
   output logic [PBL_AXI_AW-1:0] regRdAddr,
   input wire logic [31:0] regRdData
);

   logic awHeld_ff;  // write address captured
   logic wHeld_ff;  // write data captured
   logic bvalid_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [PBL_AXI_AW-1:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0] wStrb_ff;

   // no new write until the response is gone
   assign awready = !awHeld_ff && !bvalid_ff;
   assign wready = !wHeld_ff && !bvalid_ff;
   assign arready = !rvalid_ff;
   assign bvalid = bvalid_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign bresp = 2'h0;  // unmapped writes are ignored, answered okay
   assign rresp = 2'h0;  // unmapped reads return zero
   assign regWrEn = awHeld_ff && wHeld_ff;
   assign regWrAddr = awAddr_ff;
   assign regWrData = wData_ff;
   assign regWrStrb = wStrb_ff;
   assign regRdAddr = araddr;

   ////////////////////////////////////////////////////////////////////////////
   // write path: capture both halves, commit, respond
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         awAddr_ff <= '0;
         wData_ff <= '0;
         wStrb_ff <= '0;
      end else begin
         if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_ff <= 1'b1;
            wData_ff <= wdata;
            wStrb_ff <= wstrb;
         end
         if (regWrEn) begin  // commit cycle
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bvalid_ff <= 1'b1;
         end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data sampled at the address handshake
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
      end else if (arvalid && arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= regRdData;
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
      end
   end

endmodule

// File: hw/pbl_boot_loader.sv
// pbl_boot_loader: chooses and loads the program source when the cpu enters run
// assumes: all inputs synchronous to clock; straps stable from reset release;
// tool writes are refused outside stop
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// RULE1 - module fitted in stop gives flash run
// RULE2 - load 128 kbyte mid, double on large
// RULE3 - switches off-off: run from ram
// RULE4 - switch two on: run from flash; code needs switch one off too, both on runs from ram
// RULE5 - sample module at run entry
// RULE6 - present module copied to ram, then run
// RULE7 - copy overwrites ram at once, unconfirmed
// RULE8 - module-present flag follows the connector
// RULE9 - flash-run flag while in flash operation
// RULE10 - module writes accepted only in stop
// RULE11 - on-board variant has no module connector
// RULE12 - flags drop when absent or ram run
module pbl_boot_loader
   import pbl_pkg::*;
#(
   parameter int unsigned MID_WORDS = PBL_MID_BYTES / PBL_STEP_BYTES,
   parameter int unsigned LARGE_WORDS = PBL_LARGE_FACTOR * MID_WORDS
) (
   input wire logic clock,
   input wire logic rst_n,
   // axi4-lite register port
   input wire logic awvalid,
   output logic awready,
   input wire logic [PBL_AXI_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [PBL_AXI_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // mode key and straps
   input wire logic keyRun,
   input wire logic onboardStrap,
   input wire logic largeStrap,
   input wire logic [1:0] dipSwitch,
   // program module connector
   input wire logic modPresent,
   output logic modRdReq,
   output logic [PBL_RAM_AW-1:0] modRdAddr,
   input wire logic modRdAck,
   input wire logic [31:0] modRdData,
   // programming tool write path
   input wire logic toolWrReq,
   input wire logic [PBL_RAM_AW-1:0] toolWrAddr,
   input wire logic [31:0] toolWrData,
   output logic modWrEn,
   output logic [PBL_RAM_AW-1:0] modWrAddr,
   output logic [31:0] modWrData,
   // internal program ram
   output logic ramWe,
   output logic [PBL_RAM_AW-1:0] ramAddr,
   output logic [31:0] ramWdata,
   // execution and status
   output logic execRun,
   output logic execFlash,
   output logic moduleFlag,
   output logic flashRunFlag,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   pbl_state_t state_ff;  // boot sequencer
   pbl_state_t nxt_state;
   logic strapDone_ff;  // straps captured after reset
   logic onboard_ff;  // on-board flash variant
   logic large_ff;  // larger cpu, twice the module size
   logic remoteRun_ff;  // software run request
   logic flashMode_ff;  // run entered in flash operation
   logic execRun_ff;
   logic execFlash_ff;
   logic moduleFlag_ff;
   logic flashRunFlag_ff;
   logic modWrEn_ff;
   logic [PBL_RAM_AW-1:0] modWrAddr_ff;
   logic [31:0] modWrData_ff;
   logic [PBL_IRQ_W-1:0] irqStat_ff;  // sticky events
   logic [PBL_IRQ_W-1:0] irqMask_ff;
   logic [PBL_IRQ_W-1:0] irqEvent;
   logic runReq;  // key or software asks for run
   logic modSeen;  // module present on a variant that has a connector
   logic copyStart;
   logic copyBusy;
   logic copyDone;
   logic [PBL_CNT_W-1:0] copyWords;
   logic [PBL_CNT_W-1:0] copied;
   logic wrRefused;
   logic regWrEn;
   logic [PBL_AXI_AW-1:0] regWrAddr;
   logic [31:0] regWrData;
   logic [3:0] regWrStrb;
   logic [PBL_AXI_AW-1:0] regRdAddr;
   logic [31:0] regRdData;

   ////////////////////////////////////////////////////////////////////////////
   // bus front end
   pbl_axil_slave u_bus (
      .clock(clock),
      .rst_n(rst_n),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .arvalid(arvalid),
      .arready(arready),
      .araddr(araddr),
      .rvalid(rvalid),
      .rready(rready),
      .rdata(rdata),
      .rresp(rresp),
      .regWrEn(regWrEn),
      .regWrAddr(regWrAddr),
      .regWrData(regWrData),
      .regWrStrb(regWrStrb),
      .regRdAddr(regRdAddr),
      .regRdData(regRdData)
   );

   ////////////////////////////////////////////////////////////////////////////
   // straps caught once after release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         strapDone_ff <= 1'b0;
         onboard_ff <= 1'b0;
         large_ff <= 1'b0;
      end else if (!strapDone_ff) begin
         strapDone_ff <= 1'b1;
         onboard_ff <= onboardStrap;
         large_ff <= largeStrap;
      end
   end

   // no connector on the on-board variant; blind until straps are known
   assign modSeen = modPresent && strapDone_ff && !onboard_ff;  // RULE11
   assign runReq = keyRun || remoteRun_ff;
   // larger cpu loads twice the mid-range module
   assign copyWords = large_ff ? PBL_CNT_W'(LARGE_WORDS) : PBL_CNT_W'(MID_WORDS);  // RULE2

   ////////////////////////////////////////////////////////////////////////////
   // boot sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         PBL_STOP: begin
            // straps must be known before the first run entry
            if (runReq && strapDone_ff) begin
               nxt_state = PBL_SAMPLE;
            end
         end
         PBL_SAMPLE: begin
            // presence looked at once per run entry
            if (onboard_ff) begin
               if (dipSwitch == PBL_DIP_FLASH) begin
                  nxt_state = PBL_RUN_FLASH;  // RULE4
               end else begin
                  nxt_state = PBL_RUN_RAM;  // RULE3
               end
            end else if (modSeen) begin
               nxt_state = PBL_COPY;  // RULE5 RULE1
            end else begin
               nxt_state = PBL_RUN_RAM;
            end
         end
         PBL_COPY: begin
            // a half-loaded ram is never run; leaving run mid-copy still finishes it
            if (copyDone) begin
               nxt_state = runReq ? PBL_RUN_RAM : PBL_STOP;  // RULE6
            end
         end
         PBL_RUN_RAM, PBL_RUN_FLASH: begin
            if (!runReq) begin
               nxt_state = PBL_STOP;
            end
         end
         default: begin
            nxt_state = PBL_STOP;
         end
      endcase
   end

   // boot sequencer state register
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_ff <= PBL_STOP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // copy starts at once, unconfirmed
   assign copyStart = (state_ff == PBL_SAMPLE) && !onboard_ff && modSeen;  // RULE7

   ////////////////////////////////////////////////////////////////////////////
   // module to ram copy
   pbl_copy_engine u_copy (
      .clock(clock),
      .rst_n(rst_n),
      .start(copyStart),
      .wordCount(copyWords),
      .modRdReq(modRdReq),
      .modRdAddr(modRdAddr),
      .modRdAck(modRdAck),
      .modRdData(modRdData),
      .ramWe(ramWe),
      .ramAddr(ramAddr),
      .ramWdata(ramWdata),
      .busy(copyBusy),
      .done(copyDone),
      .copied(copied)
   );

   ////////////////////////////////////////////////////////////////////////////
   // flash operation chosen at run entry
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flashMode_ff <= 1'b0;
      end else if (state_ff == PBL_SAMPLE) begin
         if (onboard_ff) begin
            flashMode_ff <= (dipSwitch == PBL_DIP_FLASH);  // RULE4
         end else begin
            flashMode_ff <= modSeen;  // RULE1
         end
      end else if (state_ff == PBL_STOP) begin
         flashMode_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // execution outputs and status flags
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         execRun_ff <= 1'b0;
         execFlash_ff <= 1'b0;
         moduleFlag_ff <= 1'b0;
         flashRunFlag_ff <= 1'b0;
      end else begin
         execRun_ff <= (nxt_state == PBL_RUN_RAM) || (nxt_state == PBL_RUN_FLASH);
         // only on-board flash is fetched directly
         execFlash_ff <= (nxt_state == PBL_RUN_FLASH);  // RULE4
         moduleFlag_ff <= modSeen;  // RULE8 RULE12
         // low for a plain ram run
         flashRunFlag_ff <= flashMode_ff &&
            ((state_ff == PBL_RUN_RAM) || (state_ff == PBL_RUN_FLASH));  // RULE9 RULE12
      end
   end

   assign execRun = execRun_ff;
   assign execFlash = execFlash_ff;
   assign moduleFlag = moduleFlag_ff;
   assign flashRunFlag = flashRunFlag_ff;

   ////////////////////////////////////////////////////////////////////////////
   // tool writes pass only while stopped
   assign wrRefused = toolWrReq && (state_ff != PBL_STOP);  // RULE10

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         modWrEn_ff <= 1'b0;
         modWrAddr_ff <= '0;
         modWrData_ff <= '0;
      end else begin
         modWrEn_ff <= toolWrReq && (state_ff == PBL_STOP);  // RULE10
         if (toolWrReq) begin
            modWrAddr_ff <= toolWrAddr;
            modWrData_ff <= toolWrData;
         end
      end
   end

   assign modWrEn = modWrEn_ff;
   assign modWrAddr = modWrAddr_ff;
   assign modWrData = modWrData_ff;

   ////////////////////////////////////////////////////////////////////////////
   // software run request
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         remoteRun_ff <= PBL_CTRL_RESET[PBL_CTRL_RUN];
      end else if (regWrEn && regWrStrb[0] && (regWrAddr == PBL_ADDR_CTRL)) begin
         remoteRun_ff <= regWrData[PBL_CTRL_RUN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt events
   always_comb begin
      irqEvent = '0;
      irqEvent[PBL_IRQ_RUN_ENTRY] = (state_ff == PBL_SAMPLE);
      irqEvent[PBL_IRQ_COPY_DONE] = copyDone;
      irqEvent[PBL_IRQ_WR_REFUSED] = wrRefused;
   end

   // sticky status; a new event in the clearing cycle survives the clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqStat_ff <= PBL_IRQ_RESET;
      end else if (regWrEn && regWrStrb[0] && (regWrAddr == PBL_ADDR_IRQ_STAT)) begin
         irqStat_ff <= (irqStat_ff & ~regWrData[PBL_IRQ_W-1:0]) | irqEvent;
      end else begin
         irqStat_ff <= irqStat_ff | irqEvent;
      end
   end

   // mask register, same layout as the status
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irqMask_ff <= PBL_IRQ_RESET;
      end else if (regWrEn && regWrStrb[0] && (regWrAddr == PBL_ADDR_IRQ_MASK)) begin
         irqMask_ff <= regWrData[PBL_IRQ_W-1:0];
      end
   end

   assign irq = |(irqStat_ff & irqMask_ff);

   ////////////////////////////////////////////////////////////////////////////
   // read mux, unmapped reads zero
   always_comb begin
      regRdData = '0;
      case (regRdAddr)
         PBL_ADDR_CTRL: begin
            regRdData[PBL_CTRL_RUN] = remoteRun_ff;
         end
         PBL_ADDR_STATUS: begin
            regRdData[PBL_ST_MODULE] = moduleFlag_ff;
            regRdData[PBL_ST_FLASH] = flashRunFlag_ff;
            regRdData[PBL_ST_EXEC] = execRun_ff;
            regRdData[PBL_ST_BUSY] = copyBusy;
            regRdData[PBL_ST_ONBOARD] = onboard_ff;
            regRdData[PBL_ST_LARGE] = large_ff;
         end
         PBL_ADDR_IRQ_STAT: begin
            regRdData[PBL_IRQ_W-1:0] = irqStat_ff;
         end
         PBL_ADDR_IRQ_MASK: begin
            regRdData[PBL_IRQ_W-1:0] = irqMask_ff;
         end
         PBL_ADDR_COPY_CNT: begin
            regRdData[PBL_CNT_W-1:0] = copied;
         end
         default: begin
            regRdData = '0;
         end
      endcase
   end

endmodule

// File: hw/pbl_copy_engine.sv
// pbl_copy_engine: copies program module words into internal ram
// assumes: one ack cycle per module word
`timescale 1ns/10ps
module pbl_copy_engine
   import pbl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [PBL_CNT_W-1:0] wordCount,
   output logic modRdReq,
   output logic [PBL_RAM_AW-1:0] modRdAddr,
   input wire logic modRdAck,
   input wire logic [31:0] modRdData,
   output logic ramWe,
   output logic [PBL_RAM_AW-1:0] ramAddr,
   output logic [31:0] ramWdata,
   output logic busy,
   output logic done,
   output logic [PBL_CNT_W-1:0] copied
);

   logic busy_ff;
   logic done_ff;
   logic ramWe_ff;
   logic [PBL_RAM_AW-1:0] ramAddr_ff;
   logic [31:0] ramWdata_ff;
   logic [PBL_CNT_W-1:0] copied_ff;  // words written so far
   logic [PBL_CNT_W-1:0] limit_ff;

   assign busy = busy_ff;
   assign done = done_ff;
   assign modRdReq = busy_ff;  // held for the whole copy, dropped only after the module acks the last word
   assign modRdAddr = copied_ff[PBL_RAM_AW-1:0];
   assign ramWe = ramWe_ff;
   assign ramAddr = ramAddr_ff;
   assign ramWdata = ramWdata_ff;
   assign copied = copied_ff;

   ////////////////////////////////////////////////////////////////////////////
   // every ack becomes one ram write
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         ramWe_ff <= 1'b0;
         ramAddr_ff <= '0;
         ramWdata_ff <= '0;
         copied_ff <= '0;
         limit_ff <= '0;
      end else begin
         done_ff <= 1'b0;
         ramWe_ff <= 1'b0;
         if (start && !busy_ff) begin
            busy_ff <= 1'b1;
            copied_ff <= '0;
            limit_ff <= wordCount;
         end else if (busy_ff && modRdAck) begin
            ramWe_ff <= 1'b1;
            ramAddr_ff <= copied_ff[PBL_RAM_AW-1:0];
            ramWdata_ff <= modRdData;
            copied_ff <= copied_ff + 1'b1;
            if (copied_ff + 1'b1 == limit_ff) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end
         end
      end
   end

endmodule

// File: hw/pbl_pkg.sv
// pbl_pkg: shared constants and types of the program boot source loader
// assumes: 32-bit axi4-lite register access, 4-byte program steps
package pbl_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses, one aligned word each)
   localparam int PBL_AXI_AW = 8;
   localparam logic [7:0] PBL_ADDR_CTRL = 8'h00;  // software run request
   localparam logic [7:0] PBL_ADDR_STATUS = 8'h04;  // live state, read only
   localparam logic [7:0] PBL_ADDR_IRQ_STAT = 8'h08;  // sticky events, write one to clear
   localparam logic [7:0] PBL_ADDR_IRQ_MASK = 8'h0C;  // event enables
   localparam logic [7:0] PBL_ADDR_COPY_CNT = 8'h10;  // words copied by last load

   // ctrl fields
   localparam int PBL_CTRL_RUN = 0;
   localparam logic [31:0] PBL_CTRL_RESET = 32'h0000_0000;

   // status fields
   localparam int PBL_ST_MODULE = 0;  // module_present_flag
   localparam int PBL_ST_FLASH = 1;  // flash_run_flag
   localparam int PBL_ST_EXEC = 2;  // program executing
   localparam int PBL_ST_BUSY = 3;  // module copy in progress
   localparam int PBL_ST_ONBOARD = 4;  // on-board flash variant strap
   localparam int PBL_ST_LARGE = 5;  // larger cpu strap

   // interrupt events
   localparam int PBL_IRQ_W = 3;
   localparam int PBL_IRQ_RUN_ENTRY = 0;
   localparam int PBL_IRQ_COPY_DONE = 1;
   localparam int PBL_IRQ_WR_REFUSED = 2;
   localparam logic [PBL_IRQ_W-1:0] PBL_IRQ_RESET = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // program store size
   localparam int PBL_STEP_BYTES = 4;
   localparam int PBL_MID_KBYTES = 128;  // 32k steps
   localparam int PBL_MID_BYTES = PBL_MID_KBYTES * 1024;
   localparam int PBL_LARGE_FACTOR = 2;  // larger cpu module holds twice
   localparam int PBL_RAM_AW = 16;  // word address, covers the larger module
   localparam int PBL_CNT_W = PBL_RAM_AW + 1;

   // source-select switches: bit 0 is switch one, bit 1 is switch two
   localparam logic [1:0] PBL_DIP_RAM = 2'h0;
   localparam logic [1:0] PBL_DIP_FLASH = 2'h2;

   // boot sequencer states
   typedef enum logic [2:0] {
      PBL_STOP,
      PBL_SAMPLE,
      PBL_COPY,
      PBL_RUN_RAM,
      PBL_RUN_FLASH
   } pbl_state_t;

endpackage

// File: tb/pbl_boot_loader_props.sv
// pbl_boot_loader_props: port checks of the boot source loader
// assumes: one clock, straps only change while rst_n is low
`timescale 1ns/10ps
module pbl_boot_loader_props
   import pbl_pkg::*;
(
   input wire logic clock, rst_n, onboardStrap, keyRun, modPresent, modRdReq, modRdAck,
   input wire logic toolWrReq, modWrEn, ramWe, execRun, execFlash, moduleFlag, flashRunFlag,
   input wire logic [1:0] dipSwitch,
   input wire logic [PBL_RAM_AW-1:0] modRdAddr, ramAddr,
   input wire logic [31:0] modRdData, ramWdata
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   property p_tool; modWrEn |-> $past(toolWrReq) && !$past(execRun | modRdReq); endproperty
   a_tool: assert property (p_tool) else $error("tool write out of stop");
   // each module word lands in ram one cycle later
   property p_pair; modRdAck |=> ramWe && ramAddr == $past(modRdAddr)
      && ramWdata == $past(modRdData); endproperty
   a_pair: assert property (p_pair) else $error("ram copy mismatch");
   property p_cause; ramWe |-> $past(modRdAck); endproperty
   a_cause: assert property (p_cause) else $error("stray ram write");
   property p_noconn; onboardStrap |-> !modRdReq; endproperty
   a_noconn: assert property (p_noconn) else $error("module read on board");
   // straps settle one edge after reset
   property p_mflag; $past(rst_n, 2) |-> moduleFlag == $past(modPresent && !onboardStrap);
   endproperty
   a_mflag: assert property (p_mflag) else $error("module flag wrong");
   property p_sample; $rose(keyRun) && !execRun && !modRdReq && moduleFlag && modPresent
      |-> ##[1:3] modRdReq; endproperty
   a_sample: assert property (p_sample) else $error("no copy at run");
   property p_ramrun; $rose(keyRun) && !execRun && !modPresent && !moduleFlag && !onboardStrap
      |-> ##[1:4] execRun ##1 !flashRunFlag; endproperty
   a_ramrun: assert property (p_ramrun) else $error("ram run wrong");
   property p_fsrc; $rose(execFlash) |-> execRun && onboardStrap && dipSwitch == PBL_DIP_FLASH;
   endproperty
   a_fsrc: assert property (p_fsrc) else $error("flash run wrong");
   property p_rsrc; execRun && onboardStrap && dipSwitch == PBL_DIP_RAM
      |-> !execFlash && !flashRunFlag; endproperty
   a_rsrc: assert property (p_rsrc) else $error("flash used in ram mode");
   property p_fflag; $rose(execRun) && (moduleFlag || execFlash) |=> flashRunFlag; endproperty
   a_fflag: assert property (p_fflag) else $error("flash flag missing");
endmodule
bind pbl_boot_loader pbl_boot_loader_props u_props (.*);

// File: tb/pbl_boot_loader_tb.sv
// pbl_boot_loader_tb: queue-scored bench of the boot source loader
// assumes: model answers module reads
`timescale 1ns/10ps
module pbl_boot_loader_tb import pbl_pkg::*;;
   logic clock = '0, rst_n = '0, awvalid = '0, wvalid = '0, bready = '1, arvalid = '0;
   logic rready = '1, keyRun = '0, onboardStrap = '0, largeStrap = '0, modPresent = '0;
   logic toolWrReq = '0, slow = '0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, toolWrData = '0, seed = 32'h0000_000E;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] dipSwitch = '0;
   logic [15:0] toolWrAddr = '0;
   logic awready, wready, bvalid, arready, rvalid, modRdReq, modRdAck, modWrEn, ramWe, irq;
   logic execRun, execFlash, moduleFlag, flashRunFlag;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, modRdData, modWrData, ramWdata;
   logic [15:0] modRdAddr, modWrAddr, ramAddr;
   logic [49:0] notes[$]; // expected events, oldest first
   int failCount = 0, totalChecks = 0, cycles = 0;
   pbl_boot_loader #(.MID_WORDS(8), .LARGE_WORDS(16)) dut (.*);
   pbl_module_model u_mod (.*);
   initial begin
      forever #2 clock = ~clock;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [49:0] s, input logic [49:0] e);
      totalChecks++;
      if (s !== e) begin
         failCount++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic see(input string n, input logic [49:0] s);
      chk(n, s, notes.size() > 0 ? notes.pop_front() : '1);
   endtask
   // each result takes the oldest note
   always @(posedge clock) begin
      slow <= ^rnd();
      if (ramWe) see("ram write", {2'h0, ramAddr, ramWdata});
      if (modWrEn) see("module write", {2'h1, modWrAddr, modWrData});
      if (rvalid && rready) see("read data", {2'h2, 16'h0000, rdata});
      cycles++;
      if (cycles == 20000) begin
         failCount++;
         giveVerdict();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic rst(input logic ob, input logic lg);
      rst_n <= 1'h0;
      onboardStrap <= ob;
      largeStrap <= lg;
      cyc(5);
      rst_n <= 1'h1;
      cyc(2);
   endtask
   // ready levels settle before the edge, so they are read mid-cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ra, rw, rb;
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
      do begin
         @(negedge clock);
         {ra, rw, rb} = {awready, wready, bvalid};
         @(posedge clock);
         if (ra) awvalid <= 1'h0;
         if (rw) wvalid <= 1'h0;
      end while (!rb);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic ra, rb;
      notes.push_back({2'h2, 16'h0000, e});
      {araddr, arvalid} <= {a, 1'h1};
      do begin
         @(negedge clock);
         {ra, rb} = {arready, rvalid};
         @(posedge clock);
         if (ra) arvalid <= 1'h0;
      end while (!rb);
   endtask
   // refused tool writes leave no note
   task automatic tool(input int n, input logic ok);
      repeat (n) begin
         toolWrReq <= 1'h1;
         toolWrAddr <= 16'(rnd());
         toolWrData <= rnd();
         @(posedge clock);
         if (ok) notes.push_back({2'h1, toolWrAddr, toolWrData});
      end
      toolWrReq <= 1'h0;
   endtask
   task automatic go(input int n, input logic fl);
      for (int k = 0; k < n; k++) notes.push_back({2'h0, 16'(k), 16'h5A3C, 16'(k)});
      keyRun <= 1'h1;
      while (!execRun) @(posedge clock);
      cyc(2);
      chk("flash run flag", flashRunFlag, fl);
   endtask
   task automatic halt(input string t);
      keyRun <= 1'h0;
      while (execRun) @(posedge clock);
      cyc(3);
      $display("test %s done", t);
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      rst(1'h0, 1'h0);
      rd(PBL_ADDR_CTRL, '0);
      rd(8'h14, '0);
      wr(PBL_ADDR_IRQ_MASK, 32'h0000_0007);
      tool(3, 1'h1);
      modPresent <= 1'h1;
      cyc(2);
      chk("module flag", moduleFlag, 1'h1);
      go(8, 1'h1);
      rd(PBL_ADDR_STATUS, 32'h0000_0007);
      rd(PBL_ADDR_COPY_CNT, 32'h0000_0008);
      tool(1, 1'h0);
      rd(PBL_ADDR_IRQ_STAT, 32'h0000_0007);
      chk("irq", irq, 1'h1);
      wr(PBL_ADDR_IRQ_STAT, 32'h0000_0007);
      wr(PBL_ADDR_IRQ_MASK, '0);
      chk("irq", irq, 1'h0);
      halt("module load");
      modPresent <= 1'h0;
      cyc(2);
      chk("module flag", moduleFlag, 1'h0);
      go(0, 1'h0);
      chk("irq", irq, 1'h0);
      wr(PBL_ADDR_IRQ_MASK, 32'h0000_0001);
      chk("irq", irq, 1'h1);
      halt("ram run");
      rst(1'h0, 1'h1);
      modPresent <= 1'h1;
      cyc(2);
      go(16, 1'h1);
      halt("large module");
      rst(1'h1, 1'h0);
      chk("module flag", moduleFlag, 1'h0);
      go(0, 1'h0);
      halt("onboard ram");
      dipSwitch <= PBL_DIP_FLASH;
      wr(PBL_ADDR_CTRL, 32'h0000_0001);
      while (!execRun) @(posedge clock);
      cyc(2);
      chk("flash exec", execFlash, 1'h1);
      chk("flash run flag", flashRunFlag, 1'h1);
      wr(PBL_ADDR_CTRL, '0);
      halt("onboard flash");
      chk("notes left", notes.size(), '0);
      giveVerdict();
   end
endmodule

// File: tb/pbl_module_model.sv
// pbl_module_model: removable program module answering copy reads
// assumes: request held until the ack pulse
`timescale 1ns/10ps
module pbl_module_model
   import pbl_pkg::*;
(
   input wire logic clock, rst_n, slow, modRdReq,
   input wire logic [PBL_RAM_AW-1:0] modRdAddr,
   output logic modRdAck,
   output logic [31:0] modRdData
);
   logic [1:0] waitCnt_ff; // cycles spent on this word
   logic give; // answer at the next edge
   assign give = rst_n && modRdReq && !modRdAck && (!slow || waitCnt_ff == 2'h3);
   always_ff @(posedge clock) begin
      waitCnt_ff <= (give || !modRdReq) ? 2'h0 : waitCnt_ff + 2'h1;
   end
   // data bus toggles between words so a late read never looks valid
   always_ff @(posedge clock) begin
      modRdAck <= give;
      modRdData <= !rst_n ? 32'h0000_0000 : give ? {16'h5A3C, modRdAddr} : ~modRdData;
   end
endmodule
